// ---- hdl/eei_chan_if.sv ----
// Purpose: carries one channel's configuration and its request state
// Assumes: single clock domain
// Notes:   ctrl side is the register logic, chan side the edge detector
`timescale 1ns/1ps
interface eei_chan_if;
  logic                  enable;    // channel interrupt enable
  eei_pkg::eei_edge_type edge_sel;  // active edge select
  logic                  flag_clr;  // one-cycle clear of the request flag
  logic                  flag;      // latched request flag
  logic                  evt;       // one-cycle pulse on an accepted edge

  modport ctrl (output enable, output edge_sel, output flag_clr,
                input flag, input evt);
  modport chan (input enable, input edge_sel, input flag_clr,
                output flag, output evt);
endinterface

// ---- hdl/eei_edge_chan.sv ----
// Purpose: edge detector and request flag for one external interrupt channel
// Assumes: level input synchronous to the clock
// Notes:   while the input is not usable the previous level is held at idle high
`timescale 1ns/1ps
module eei_edge_chan (
  input  wire logic core_clk_in,  // system clock
  input  wire logic rst_b_in,     // sync reset, active low
  input  wire logic level_in,     // pin level
  input  wire logic valid_in,     // pin configured as digital input
  eei_chan_if.chan  ch            // configuration and request state
);

  logic prev_q;
  logic prev_d;
  logic flag_q;
  logic flag_d;
  logic evt_q;
  logic rise;
  logic fall;
  logic hit;

  // RULE_07 low-to-high detect
  assign rise = valid_in & level_in & ~prev_q;
  assign fall = valid_in & ~level_in & prev_q;
  // RULE_01 selected edge
  assign hit  = ch.enable &
                (((ch.edge_sel == eei_pkg::EEI_EDGE_RISE) & rise) |
                 ((ch.edge_sel == eei_pkg::EEI_EDGE_FALL) & fall) |
                 ((ch.edge_sel == eei_pkg::EEI_EDGE_BOTH) & (rise | fall)));
  // idle-high reference avoids a false rising edge when the pin is first enabled
  assign prev_d = valid_in ? level_in : 1'b1;
  // RULE_10 set beats clear
  assign flag_d = hit | (flag_q & ~ch.flag_clr);

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      prev_q <= 1'b1;
      flag_q <= 1'b0;
      evt_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
      evt_q  <= hit;
    end
  end

  assign ch.flag = flag_q;
  assign ch.evt  = evt_q;

endmodule // eei_edge_chan

// ---- hdl/eei_irq_stat.sv ----
// Purpose: sticky event status, mask and level interrupt
// Assumes: status is cleared by the read that returns it
// Notes:   an event in the clearing cycle stays set
`timescale 1ns/1ps
module eei_irq_stat #(
  parameter int unsigned N = 2                 // event count
) (
  input  wire logic         core_clk_in,       // system clock
  input  wire logic         rst_b_in,          // sync reset, active low
  input  wire logic [N-1:0] evt_in,            // one-cycle events
  input  wire logic         rd_clr_in,         // status read pulse
  input  wire logic [N-1:0] mask_in,           // enable mask
  output logic      [N-1:0] status_out,        // sticky status
  output logic              irq_out            // registered interrupt level
);

  logic [N-1:0] status_q;
  logic [N-1:0] status_d;
  logic         irq_q;

  if (N < 1) begin : g_chk
    $error("eei_irq_stat: N must be at least 1");
  end

  assign status_d = evt_in | (status_q & ~{N{rd_clr_in}});

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_in);
    end
  end

  assign status_out = status_q;
  assign irq_out    = irq_q;

endmodule // eei_irq_stat

// ---- hdl/eei_pkg.sv ----
// Purpose: shared constants for the external edge interrupt unit
// Assumes: 8-bit registers, word-aligned byte offsets on the plain register port
// Notes:   control byte holds channel a in the upper nibble, channel b in the lower
package eei_pkg;

  localparam int unsigned REG_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_PORT0_DIR   = 8'h00;
  localparam logic [7:0] OFS_IRQ_CTRL    = 8'h04;
  localparam logic [7:0] OFS_AIN_DIS_LO  = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;
  localparam logic [7:0] OFS_PIN_LEVEL   = 8'h14;

  // reset values
  localparam logic [7:0] RST_PORT0_DIR  = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL   = 8'h00;
  localparam logic [7:0] RST_AIN_DIS_LO = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK   = 8'h00;

  // per-channel field positions in ext_irq_control (base of each nibble)
  localparam int unsigned CH_A_BASE   = 4;
  localparam int unsigned CH_B_BASE   = 0;
  localparam int unsigned FLD_ENABLE  = 0;
  localparam int unsigned FLD_EDGE_LO = 1;
  localparam int unsigned FLD_FLAG    = 3;

  // port 0 pin shared by channel a
  localparam int unsigned PIN_A_BIT = 5;

  // edge select codes: {upper, lower} select bits
  typedef enum logic [1:0] {
    EEI_EDGE_NONE    = 2'h0,
    EEI_EDGE_RISE    = 2'h1,
    EEI_EDGE_FALL    = 2'h2,
    EEI_EDGE_BOTH    = 2'h3
  } eei_edge_type;

  localparam int unsigned NUM_CH = 2;

endpackage

// ---- hdl/eei_top.sv ----
// Purpose: two-channel external edge interrupt unit with port 0 direction
// Assumes: register port strobes one cycle, read data valid the cycle after
// Notes:   channel a shares port0_pin5 with an analog input
// Functional notes
// RULE_01 - enabled pin edge raises interrupt request
// RULE_02 - second channel identical, own pin
// RULE_03 - 8-bit port direction, 0 input
// RULE_04 - software disables analog input on pin5
// RULE_05 - per channel edge select and enable
// RULE_06 - enable bit 4 low blocks channel a
// RULE_07 - bits 5,6 = 1,0 select rising
// RULE_08 - enable bit 4 high permits channel a
// RULE_09 - software follows safe configuration order
// RULE_10 - flag latched until software writes 0
`timescale 1ns/1ps
module eei_top #(
  parameter int unsigned ADDR_W = 8                 // register address width
) (
  input  wire logic              core_clk_in,       // system clock 200 MHz
  input  wire logic              rst_b_in,          // sync reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,           // register byte address
  input  wire logic [7:0]        wr_data_in,        // write data
  input  wire logic              wr_en_in,          // write strobe
  input  wire logic              rd_en_in,          // read strobe
  output logic      [7:0]        rd_data_out,       // read data, cycle after strobe
  input  wire logic [7:0]        port0_pins_in,     // port 0 pin levels
  input  wire logic              ext_irq_in_b,      // dedicated pin of channel b
  output logic      [7:0]        port0_dir_out,     // port 0 direction, 1 output
  output logic                   irq_a_out,         // channel a request
  output logic                   irq_b_out,         // channel b request
  output logic                   irq_out            // masked status interrupt
);

  if (ADDR_W < 5) begin : g_chk
    $error("eei_top: ADDR_W too small for the register map");
  end

  localparam int unsigned NCH = eei_pkg::NUM_CH;

  logic [7:0]     dir_q;
  logic [7:0]     ctrl_q;
  logic [7:0]     aind_q;
  logic [NCH-1:0] mask_q;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic           irq_a_q;
  logic           irq_b_q;

  logic [7:0]     addr8;
  logic           sel_dir;
  logic           sel_ctrl;
  logic           sel_aind;
  logic           sel_stat;
  logic           sel_mask;
  logic           sel_lvl;
  logic           wr_dir;
  logic           wr_ctrl;
  logic           wr_aind;
  logic           wr_mask;
  logic           rd_stat;

  logic [NCH-1:0] ch_level;
  logic [NCH-1:0] ch_valid;
  logic [NCH-1:0] ch_flag;
  logic [NCH-1:0] ch_evt;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] status;
  logic           irq_lvl;
  logic [7:0]     ctrl_rd;
  logic [7:0]     lvl_rd;

  // address decode
  assign addr8    = 8'(addr_in);
  assign sel_dir  = (addr8 == eei_pkg::OFS_PORT0_DIR);
  assign sel_ctrl = (addr8 == eei_pkg::OFS_IRQ_CTRL);
  assign sel_aind = (addr8 == eei_pkg::OFS_AIN_DIS_LO);
  assign sel_stat = (addr8 == eei_pkg::OFS_IRQ_STATUS);
  assign sel_mask = (addr8 == eei_pkg::OFS_IRQ_MASK);
  assign sel_lvl  = (addr8 == eei_pkg::OFS_PIN_LEVEL);
  assign wr_dir   = wr_en_in & sel_dir;
  assign wr_ctrl  = wr_en_in & sel_ctrl;
  assign wr_aind  = wr_en_in & sel_aind;
  assign wr_mask  = wr_en_in & sel_mask;
  assign rd_stat  = rd_en_in & sel_stat;

  // RULE_04 pin usable only with analog input off
  assign ch_valid[0] = aind_q[eei_pkg::PIN_A_BIT] & ~dir_q[eei_pkg::PIN_A_BIT];
  assign ch_level[0] = port0_pins_in[eei_pkg::PIN_A_BIT];
  // RULE_02 own dedicated pin
  assign ch_valid[1] = 1'b1;
  assign ch_level[1] = ext_irq_in_b;

  // per channel edge logic; index 0 is channel a, 1 is channel b
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int unsigned B = (i == 0) ? eei_pkg::CH_A_BASE : eei_pkg::CH_B_BASE;
    eei_chan_if ch_if ();
    // RULE_05 per channel fields
    assign ch_if.enable   = ctrl_q[B + eei_pkg::FLD_ENABLE];
    assign ch_if.edge_sel = eei_pkg::eei_edge_type'(ctrl_q[B + eei_pkg::FLD_EDGE_LO +: 2]);
    // RULE_10 write 0 clears flag
    assign ch_if.flag_clr = wr_ctrl & ~wr_data_in[B + eei_pkg::FLD_FLAG];
    assign ch_flag[i]     = ch_if.flag;
    assign ch_evt[i]      = ch_if.evt;
    assign ch_en[i]       = ch_if.enable;
    eei_edge_chan u_chan (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .level_in    (ch_level[i]),
      .valid_in    (ch_valid[i]),
      .ch          (ch_if.chan)
    );
  end

  eei_irq_stat #(
    .N (NCH)
  ) u_stat (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .evt_in      (ch_evt),
    .rd_clr_in   (rd_stat),
    .mask_in     (mask_q),
    .status_out  (status),
    .irq_out     (irq_lvl)
  );

  // flag bits read back live; stored flag bits are never used
  assign ctrl_rd = {ch_flag[0], ctrl_q[6:4], ch_flag[1], ctrl_q[2:0]};
  assign lvl_rd  = {6'h00, ext_irq_in_b, port0_pins_in[eei_pkg::PIN_A_BIT]};

  assign rdata_d = !rd_en_in ? 8'h00 :
                   sel_dir   ? dir_q :
                   sel_ctrl  ? ctrl_rd :
                   sel_aind  ? aind_q :
                   sel_stat  ? {6'h00, status} :
                   sel_mask  ? {6'h00, mask_q} :
                   sel_lvl   ? lvl_rd : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      dir_q <= eei_pkg::RST_PORT0_DIR;
    end else if (wr_dir) begin
      // RULE_03 direction per pin
      dir_q <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ctrl_q <= eei_pkg::RST_IRQ_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      aind_q <= eei_pkg::RST_AIN_DIS_LO;
    end else if (wr_aind) begin
      aind_q <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      mask_q <= eei_pkg::RST_IRQ_MASK[NCH-1:0];
    end else if (wr_mask) begin
      mask_q <= wr_data_in[NCH-1:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // RULE_06 RULE_08 requests gated by enable
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_a_q <= ch_flag[0] & ch_en[0];
      irq_b_q <= ch_flag[1] & ch_en[1];
    end
  end

  assign rd_data_out   = rdata_q;
  assign port0_dir_out = dir_q;
  assign irq_a_out     = irq_a_q;
  assign irq_b_out     = irq_b_q;
  assign irq_out       = irq_lvl;

endmodule // eei_top

// ---- sim/eei_chk.sv ----
// Purpose: port-level checks for eei_top
// Assumes: config is shadowed from register writes
// Notes:   a request reaches its output two clocks after the pin edge
`timescale 1ns/1ps
module eei_chk #(
  parameter int unsigned ADDR_W = 8  // address width
) (
  input logic              core_clk_in,    // clock
  input logic              rst_b_in,       // reset
  input logic [ADDR_W-1:0] addr_in,        // address
  input logic [7:0]        wr_data_in,     // write data
  input logic              wr_en_in,       // write strobe
  input logic              rd_en_in,       // read strobe
  input logic [7:0]        rd_data_out,    // read data
  input logic [7:0]        port0_pins_in,  // port pins
  input logic              ext_irq_in_b,   // pin b
  input logic [7:0]        port0_dir_out,  // direction
  input logic              irq_a_out,      // request a
  input logic              irq_b_out,      // request b
  input logic              irq_out         // interrupt
);
  logic [7:0] ctl_q;
  logic [7:0] ain_q;
  logic [7:0] msk_q;
  wire wr_ctl = wr_en_in && addr_in == 8'h04;
  wire clr_a  = wr_ctl && !wr_data_in[7];
  // only the plain rising setup is tracked, other modes are left to the bench
  wire cfg_a  = ctl_q[6:4] == 3'h3 && ain_q[5] && !port0_dir_out[5];
  wire cfg_b  = ctl_q[2:0] == 3'h3;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ctl_q <= 8'h00;
      ain_q <= 8'h00;
      msk_q <= 8'h00;
    end else if (wr_en_in) begin
      if (addr_in == 8'h04) ctl_q <= wr_data_in;
      if (addr_in == 8'h08) ain_q <= wr_data_in;
      if (addr_in == 8'h10) msk_q <= wr_data_in;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_dir_write:
    assert property (wr_en_in && addr_in == 8'h00 |=> port0_dir_out == $past(wr_data_in))
    else $error("direction not written");
  a_rise_a:
    assert property (cfg_a && $past(cfg_a) && $rose(port0_pins_in[5]) |-> ##[1:2] irq_a_out)
    else $error("rise on a missed");
  a_block_a:
    assert property (!ctl_q[4] |=> !irq_a_out)
    else $error("disabled a requested");
  a_rise_b:
    assert property (cfg_b && $past(cfg_b) && $rose(ext_irq_in_b) |-> ##[1:2] irq_b_out)
    else $error("rise on b missed");
  a_flag_hold:
    assert property (irq_a_out && ctl_q[4] && !$past(clr_a) |=> irq_a_out)
    else $error("flag a dropped");
  a_flag_clear:
    assert property (clr_a && $stable(port0_pins_in[5]) |-> ##2 !irq_a_out)
    else $error("flag a not cleared");
  a_mask_off:
    assert property (msk_q[1:0] == 2'h0 && $past(msk_q[1:0]) == 2'h0 |-> !irq_out)
    else $error("masked interrupt raised");
  a_ctrl_read:
    assert property (rd_en_in && addr_in == 8'h04 |=>
                     (rd_data_out & 8'h77) == ($past(ctl_q) & 8'h77))
    else $error("control readback wrong");
  c_rise_a: cover property (cfg_a && $rose(port0_pins_in[5]));
  c_irq:    cover property (irq_out);
  c_clr:    cover property (clr_a && irq_a_out);
endmodule // eei_chk

// ---- sim/eei_sw_model.sv ----
// Purpose: two push switches on the interrupt pins
// Assumes: pull-up holds each pin high while released
// Notes:   no bounce modelled, so each press gives one clean edge pair
`timescale 1ns/1ps
module eei_sw_model (
  input  logic press_a_in,  // switch a held
  input  logic press_b_in,  // switch b held
  output logic pin_a_out,   // pin a level
  output logic pin_b_out    // pin b level
);
  assign pin_a_out = !press_a_in;
  assign pin_b_out = !press_b_in;
endmodule // eei_sw_model

// ---- sim/external_edge_interrupt_bench.sv ----
// Purpose: register-level test of eei_top
// Assumes: a pin edge reaches the request outputs within four clocks
// Notes:   the switch model drives both channel pins
`timescale 1ns/1ps
module external_edge_interrupt_bench;
  logic       core_clk_in = 0, rst_b_in = 0, wr_en_in = 0, rd_en_in = 0;
  logic [7:0] addr_in = 0, wr_data_in = 0, rd_data_out, port0_dir_out, port0_pins_in;
  logic       ext_irq_in_b, irq_a_out, irq_b_out, irq_out, prs_a = 0, prs_b = 0, pin_a;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  int         n_fail = 0, n_checks = 0;
  assign port0_pins_in = {2'b11, pin_a, 5'h1f};
  eei_top uut (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .addr_in       (addr_in),
    .wr_data_in    (wr_data_in),
    .wr_en_in      (wr_en_in),
    .rd_en_in      (rd_en_in),
    .rd_data_out   (rd_data_out),
    .port0_pins_in (port0_pins_in),
    .ext_irq_in_b  (ext_irq_in_b),
    .port0_dir_out (port0_dir_out),
    .irq_a_out     (irq_a_out),
    .irq_b_out     (irq_b_out),
    .irq_out       (irq_out)
  );
  eei_sw_model sw (.press_a_in(prs_a), .press_b_in(prs_b), .pin_a_out(pin_a),
                   .pin_b_out(ext_irq_in_b));
  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic cmp(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1 cmp(rd_data_out, exp);
  endtask
  // press then release: falling edge first, rising edge second
  task automatic edge_test(input int ch, input logic [1:0] code, input logic en);
    logic [7:0] c;
    logic [7:0] f;
    c = ch ? {5'h00, code, en} : {1'b0, code, en, 4'h0};
    wr(8'h04, 8'h00);
    wr(8'h04, c & 8'hee);
    wr(8'h04, c);
    rd(8'h04, c);
    for (int i = 0; i < 2; i++) begin
      // flag bit of this channel as it must read back after the edge
      f = ch ? {4'h0, en & code[1-i], 3'h0} : {en & code[1-i], 7'h00};
      @(posedge core_clk_in);
      if (ch) prs_b <= !i;
      else prs_a <= !i;
      repeat (4) @(posedge core_clk_in);
      #1 cmp(ch ? irq_b_out : irq_a_out, en & code[1-i]);
      cmp(irq_out, en & code[1-i]);
      rd(8'h0c, {7'h00, en & code[1-i]} << ch);
      // writing 1 to the flag bit must leave it set
      wr(8'h04, c | f);
      rd(8'h04, c | f);
      wr(8'h04, c);
      repeat (3) @(posedge core_clk_in);
      #1 cmp({irq_out, irq_a_out, irq_b_out}, 8'h00);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50us;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    wr(8'h18, 8'hff);
    foreach (ofs[j]) rd(ofs[j], 8'h00);
    rd(8'h14, 8'h03);
    wr(8'h00, 8'ha5);
    rd(8'h00, 8'ha5);
    cmp(port0_dir_out, 8'ha5);
    $display("test 1 done");
    wr(8'h08, 8'h20);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h03);
    edge_test(0, 2'h1, 1'b0);
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) edge_test(ch, k[1:0], 1'b1);
    end
    $display("test 2 done");
    // b is masked; a must stay quiet with the analog input on, then with pin 5 driven
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h33);
    for (int r = 0; r < 2; r++) begin
      wr(8'h00, r ? 8'h20 : 8'h00);
      wr(8'h08, r ? 8'h20 : 8'h00);
      prs_a <= 1'b1;
      prs_b <= 1'b1;
      rd(8'h14, 8'h00);
      repeat (4) @(posedge core_clk_in);
      prs_a <= 1'b0;
      prs_b <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1 cmp({irq_out, irq_a_out, irq_b_out}, 8'h01);
      rd(8'h0c, 8'h02);
    end
    $display("test 3 done");
    // a reset in mid-run drops every request and register
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    #1 cmp({irq_out, irq_a_out, irq_b_out}, 8'h00);
    cmp(port0_dir_out, 8'h00);
    rd(8'h04, 8'h00);
    $display("test 4 done");
    final_report;
  end
endmodule // external_edge_interrupt_bench
bind eei_top eei_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_in   (core_clk_in),
  .rst_b_in      (rst_b_in),
  .addr_in       (addr_in),
  .wr_data_in    (wr_data_in),
  .wr_en_in      (wr_en_in),
  .rd_en_in      (rd_en_in),
  .rd_data_out   (rd_data_out),
  .port0_pins_in (port0_pins_in),
  .ext_irq_in_b  (ext_irq_in_b),
  .port0_dir_out (port0_dir_out),
  .irq_a_out     (irq_a_out),
  .irq_b_out     (irq_b_out),
  .irq_out       (irq_out)
);
